// ===== dv/usdb_channel_asserts.sv
module usdb_channel_asserts
  import usdb_pkg::*;
#(
  parameter bit IS_CHANNEL0 = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usdb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic sck_in,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic rx_transfer_done,
  input wire logic tx_transfer_done,
  input wire logic debug_chan_send_status,
  input wire logic debug_chan_recv_status,
  input wire logic rx_char_available,
  input wire logic tx_holding_free
);
  import usdb_pkg::*;
  logic acc;
  logic rd_st;
  logic cmd_wr;
  logic rhr_sel;
  logic [15:0] cd_r;
  logic [1:0] cd0_cnt;
  assign acc = psel && penable;
  assign rd_st = acc && !pwrite && paddr == OFF_CHANNEL_STATUS;
  assign cmd_wr = acc && pwrite && paddr == OFF_COMMAND;
  assign rhr_sel = psel && !pwrite && paddr == OFF_RECEIVE_HOLDING;
  // -------------------------------------------------------------
  // Divisor shadow, counts settled cycles at zero
  // -------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cd_r <= '0;
      cd0_cnt <= '0;
    end else begin
      if (acc && pwrite && paddr == OFF_BAUD_DIVISOR) begin
        cd_r <= pwdata[15:0];
      end
      cd0_cnt <= (cd_r != 16'h0) ? 2'h0 : ((cd0_cnt == 2'h3) ? 2'h3 : cd0_cnt + 2'h1);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_rdy_clear_cause: assert property ($fell(rx_char_available) |->
    $past(rhr_sel || (cmd_wr && pwdata[CMD_RX_DISABLE]))) else $error("ready fell alone");
  a_txen_sets_ready: assert property (cmd_wr && pwdata[CMD_TX_ENABLE] &&
    !pwdata[CMD_TX_DISABLE] && !pwdata[CMD_BREAK_START] |=> tx_holding_free)
    else $error("enable left ready low");
  a_ready_low_reset: assert property ($fell(rst) |-> !tx_holding_free && txd)
    else $error("ready high after reset");
  a_end_rx_mirror: assert property (rd_st && $rose(penable) |->
    prdata[ST_END_RX] == $past(rx_transfer_done)) else $error("rx end bit wrong");
  a_end_tx_mirror: assert property (rd_st && $rose(penable) |->
    prdata[ST_END_TX] == $past(tx_transfer_done)) else $error("tx end bit wrong");
  a_dbg_bits: assert property (rd_st && $rose(penable) |-> prdata[31:30] ==
    (IS_CHANNEL0 ? {$past(debug_chan_recv_status), $past(debug_chan_send_status)} : 2'h0))
    else $error("debug bits wrong");
  a_rhr_upper_zero: assert property (acc && rhr_sel |-> prdata[31:9] == 23'h0)
    else $error("holding upper bits set");
  a_cd_zero_still: assert property (cd0_cnt == 2'h3 |=> $stable(sck_out))
    else $error("serial clock moved at divisor zero");
  c_overrun: cover property (rd_st && prdata[ST_OVERRUN]);
  c_rx_char: cover property ($rose(rx_char_available));
  c_tx_busy: cover property ($fell(tx_holding_free));
endmodule

bind usdb_channel usdb_channel_asserts #(.IS_CHANNEL0(IS_CHANNEL0)) chk_u (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
  .rx_transfer_done(rx_transfer_done), .tx_transfer_done(tx_transfer_done),
  .debug_chan_send_status(debug_chan_send_status),
  .debug_chan_recv_status(debug_chan_recv_status),
  .rx_char_available(rx_char_available), .tx_holding_free(tx_holding_free));

// ===== dv/usdb_channel_tb_top.sv
module usdb_channel_tb_top
  import usdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 32;
  localparam logic [7:0] ST = OFF_CHANNEL_STATUS;
  localparam logic [7:0] RHR = OFF_RECEIVE_HOLDING;
  localparam logic [7:0] THR = OFF_TRANSMIT_HOLDING;
  localparam logic [7:0] TOR = OFF_RECEIVE_IDLE_TIMEOUT;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd, sck_in;
  logic rx_transfer_done, tx_transfer_done, debug_chan_send_status, debug_chan_recv_status;
  logic rx_char_available, tx_holding_free, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] c;
  int num_errors, samples_checked;
  usdb_channel #(.IS_CHANNEL0(1'b1)) dut_u (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_in(sck_in),
    .sck_out(), .sck_oe(), .rx_transfer_done(rx_transfer_done),
    .tx_transfer_done(tx_transfer_done), .debug_chan_send_status(debug_chan_send_status),
    .debug_chan_recv_status(debug_chan_recv_status), .rx_char_available(rx_char_available),
    .tx_holding_free(tx_holding_free));
  usdb_remote_model peer_u (.mclk(mclk), .txd(txd), .rxd(rxd));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      num_errors++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input int b);
    apb(1'b1, OFF_COMMAND, 32'h1 << b);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, ST, 32'h0);
    chk(q & m, x);
  endtask
  task automatic rx(input logic [8:0] d, input int par, input logic stp);
    peer_u.send(d, 8, BT, par, stp);
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    st(32'hffff_ffff, 32'h0);
    apb(1'b1, OFF_BAUD_DIVISOR, 32'h0001_2345);
    apb(1'b0, OFF_BAUD_DIVISOR, 32'h0);
    chk(q, 32'h0000_2345);
    apb(1'b1, TOR, 32'h0000_01ff);
    apb(1'b0, TOR, 32'h0);
    chk(q, 32'h0000_00ff);
    apb(1'b1, TOR, 32'h0);
    apb(1'b1, OFF_BAUD_DIVISOR, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_mirror();
    rx_transfer_done <= 1'b1;
    debug_chan_send_status <= 1'b1;
    st(32'hc000_0018, 32'h4000_0008);
    rx_transfer_done <= 1'b0;
    tx_transfer_done <= 1'b1;
    debug_chan_send_status <= 1'b0;
    debug_chan_recv_status <= 1'b1;
    st(32'hc000_0018, 32'h8000_0010);
    $display("mirror done");
  endtask
  task automatic t_tx();
    apb(1'b1, OFF_MODE, 32'h4c);
    cmd(CMD_TX_ENABLE);
    st(32'h202, 32'h202);
    apb(1'b1, THR, 32'h1a5);
    repeat (100) @(posedge mclk);
    chk({31'h0, txd}, 32'h1);
    st(32'h200, 32'h0);
    fork
      begin
        int n;
        apb(1'b1, OFF_BAUD_DIVISOR, 32'h2);
        // Second character only once the first has left holding
        n = 0;
        while (tx_holding_free !== 1'b1 && n < 200) begin
          @(posedge mclk);
          n++;
        end
        chk({31'h0, tx_holding_free}, 32'h1);
        apb(1'b1, THR, 32'h13c);
        chk({31'h0, tx_holding_free}, 32'h0);
      end
      begin
        peer_u.get(8, BT, c);
        chk({23'h0, c}, 32'h0a5);
        peer_u.get(8, BT, c);
        chk({23'h0, c}, 32'h03c);
      end
    join
    repeat (2 * BT) @(posedge mclk);
    st(32'h202, 32'h202);
    cmd(CMD_BREAK_START);
    repeat (2 * BT) @(posedge mclk);
    chk({31'h0, txd}, 32'h0);
    st(32'h200, 32'h0);
    cmd(CMD_BREAK_STOP);
    repeat (3 * BT) @(posedge mclk);
    st(32'h202, 32'h202);
    cmd(CMD_TX_DISABLE);
    st(32'h202, 32'h0);
    $display("tx done");
  endtask
  task automatic t_rx();
    logic [31:0] md[4] = '{32'h0c, 32'h2c, 32'h6c, 32'h0c};
    int pb[4] = '{1, 0, 1, 0};
    logic [31:0] pe[4] = '{32'h0, 32'h0, 32'h80, 32'h80};
    cmd(CMD_RX_ENABLE);
    rx(9'h03c, -1, 1'b1);
    st(32'h1e5, 32'h1);
    chk({31'h0, rx_char_available}, 32'h1);
    apb(1'b0, RHR, 32'h0);
    chk(q, 32'h3c);
    chk({31'h0, rx_char_available}, 32'h0);
    rx(9'h011, -1, 1'b1);
    rx(9'h022, -1, 1'b1);
    st(32'h21, 32'h21);
    apb(1'b0, RHR, 32'h0);
    chk(q, 32'h22);
    rx(9'h055, -1, 1'b0);
    st(32'h40, 32'h40);
    apb(1'b0, RHR, 32'h0);
    rx(9'h000, -1, 1'b0);
    st(32'h5, 32'h4);
    cmd(CMD_RESET_STATUS);
    st(32'h1e4, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_MODE, md[i]);
      cmd(CMD_RESET_STATUS);
      rx(9'h007, pb[i], 1'b1);
      st(32'h80, pe[i]);
      apb(1'b0, RHR, 32'h0);
    end
    apb(1'b1, OFF_MODE, 32'h4c);
    $display("rx done");
  endtask
  task automatic t_timeout();
    apb(1'b1, TOR, 32'h1);
    st(32'h100, 32'h0);
    rx(9'h0a5, -1, 1'b1);
    st(32'h100, 32'h0);
    repeat (4 * BT) @(posedge mclk);
    st(32'h100, 32'h100);
    cmd(CMD_START_TIMEOUT);
    st(32'h100, 32'h0);
    $display("timeout done");
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, sck_in, rx_transfer_done, tx_transfer_done} = 6'h0;
    {debug_chan_send_status, debug_chan_recv_status} = 2'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_mirror();
    t_tx();
    t_rx();
    t_timeout();
    conclude();
  end
endmodule

// ===== dv/usdb_remote_model.sv
module usdb_remote_model (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // Frame: start, data LSB first, optional parity, one stop
  // -------------------------------------------------------------
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] c, input int n, input int bt, input int par,
                      input logic stp);
    rxd <= 1'b0;
    repeat (bt) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxd <= c[i];
      repeat (bt) @(posedge mclk);
    end
    if (par >= 0) begin
      rxd <= par[0];
      repeat (bt) @(posedge mclk);
    end
    rxd <= stp;
    repeat (bt) @(posedge mclk);
    rxd <= 1'b1;
    repeat (bt) @(posedge mclk);
  endtask
  // Samples mid-bit; returns at mid stop so the next start is seen
  task automatic get(input int n, input int bt, output logic [8:0] c);
    int w;
    w = 0;
    c = '0;
    while (txd !== 1'b0 && w < 4000) begin
      @(posedge mclk);
      w++;
    end
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge mclk);
      c[i] = txd;
    end
    repeat (bt) @(posedge mclk);
    if (txd !== 1'b1 || w == 4000) c = 9'h1ff;
  endtask
endmodule

// ===== shared/usdb_pkg.sv
package usdb_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB word bus)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RECEIVE_HOLDING = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_TRANSMIT_HOLDING = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_RECEIVE_IDLE_TIMEOUT = 8'h24;

  // ----------------------------------------------------------------
  // Command register bits (write one to act, reads as zero)
  // ----------------------------------------------------------------
  localparam int CMD_RESET_STATUS = 0;
  localparam int CMD_RX_ENABLE = 1;
  localparam int CMD_RX_DISABLE = 2;
  localparam int CMD_TX_ENABLE = 3;
  localparam int CMD_TX_DISABLE = 4;
  localparam int CMD_BREAK_START = 5;
  localparam int CMD_BREAK_STOP = 6;
  localparam int CMD_START_TIMEOUT = 7;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_W = 8;
  localparam int MODE_SYNC = 0;
  localparam int MODE_EXT_CLOCK = 1;
  localparam int MODE_CHRL_LSB = 2;
  localparam int MODE_NINE_BIT = 4;
  localparam int MODE_PAR_LSB = 5;
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h2;
  localparam logic [1:0] PAR_MULTIDROP = 2'h3;

  // ----------------------------------------------------------------
  // Channel status bit positions
  // ----------------------------------------------------------------
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_BREAK = 2;
  localparam int ST_END_RX = 3;
  localparam int ST_END_TX = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_PARITY = 7;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_TX_EMPTY = 9;
  localparam int ST_DBG_SEND = 30;
  localparam int ST_DBG_RECV = 31;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int CHAR_W = 9;
  localparam int CD_W = 16;
  localparam int TO_W = 8;
  localparam int TO_CNT_W = 10;
  localparam logic [3:0] CHRL_BASE = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_HALF = 4'h8;
  localparam logic [1:0] TO_BITS_PER_UNIT = 2'h0;

  typedef enum logic [2:0] {
    USDB_RX_IDLE = 3'b000,
    USDB_RX_START = 3'b001,
    USDB_RX_DATA = 3'b010,
    USDB_RX_PAR = 3'b011,
    USDB_RX_STOP = 3'b100,
    USDB_RX_BREAK = 3'b101
  } usdb_rx_state_t;

  typedef enum logic [2:0] {
    USDB_TX_IDLE = 3'b000,
    USDB_TX_DATA = 3'b001,
    USDB_TX_PAR = 3'b010,
    USDB_TX_STOP = 3'b011,
    USDB_TX_BREAK = 3'b100
  } usdb_tx_state_t;

endpackage

// ===== verilog/usdb_channel.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
module usdb_channel
  import usdb_pkg::*;
#(
  parameter bit IS_CHANNEL0 = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [usdb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic rx_transfer_done,
  input wire logic tx_transfer_done,
  input wire logic debug_chan_send_status,
  input wire logic debug_chan_recv_status,
  output logic rx_char_available,
  output logic tx_holding_free
);
  import usdb_pkg::*;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic [MODE_W-1:0] mode;
    logic [CD_W-1:0] baud_divisor_value;
    logic [TO_W-1:0] idle_limit_value;
    logic rxd_s1;
    logic rxd_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_prev;
    logic sck_level;
    logic [CD_W-1:0] div_cnt;
    logic [3:0] os_cnt;
    usdb_rx_state_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_cnt;
    logic [CHAR_W-1:0] rx_shift;
    logic rx_pbit;
    logic [CHAR_W-1:0] rx_hold;
    logic rx_ready;
    logic break_seen_flag;
    logic rx_overrun_flag;
    logic frame_flag;
    logic parity_fault_flag;
    logic [TO_CNT_W-1:0] to_cnt;
    logic to_run;
    logic to_flag;
    usdb_tx_state_t tx_st;
    logic [CHAR_W-1:0] tx_hold;
    logic tx_full;
    logic [CHAR_W-1:0] tx_shift;
    logic [3:0] tx_cnt;
    logic tx_par;
    logic tx_low;
    logic brk_pend;
    logic [31:0] rdata;
    logic rerr;
  } usdb_state_t;

  usdb_state_t s_r;
  usdb_state_t s_nxt;

  // ----------------------------------------------------------------
  // Character helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] char_bits(input logic [MODE_W-1:0] m);
    if (m[MODE_NINE_BIT]) begin
      char_bits = NINE_BITS;
    end else begin
      char_bits = CHRL_BASE + {2'h0, m[MODE_CHRL_LSB +: 2]};
    end
  endfunction

  function automatic logic par_calc(input logic [CHAR_W-1:0] d,
                                    input logic [MODE_W-1:0] m);
    par_calc = (m[MODE_PAR_LSB +: 2] == PAR_ODD) ? ~^d : ^d;
  endfunction

  logic [31:0] status_word;
  logic [3:0] nb;
  logic [1:0] pmode;
  logic sync_m;
  logic ext_m;

  always_comb begin
    nb = char_bits(s_r.mode);
    pmode = s_r.mode[MODE_PAR_LSB +: 2];
    sync_m = s_r.mode[MODE_SYNC];
    ext_m = s_r.mode[MODE_EXT_CLOCK];
    status_word = '0;
    status_word[ST_RX_READY] = s_r.rx_ready;
    status_word[ST_TX_READY] = s_r.tx_en & ~s_r.tx_full & ~s_r.brk_pend;
    status_word[ST_BREAK] = s_r.break_seen_flag;
    status_word[ST_END_RX] = rx_transfer_done;
    status_word[ST_END_TX] = tx_transfer_done;
    status_word[ST_OVERRUN] = s_r.rx_overrun_flag;
    status_word[ST_FRAME] = s_r.frame_flag;
    status_word[ST_PARITY] = s_r.parity_fault_flag;
    status_word[ST_TIMEOUT] = s_r.to_flag & (s_r.idle_limit_value != '0);
    status_word[ST_TX_EMPTY] = s_r.tx_en & ~s_r.tx_full & ~s_r.brk_pend
                             & (s_r.tx_st == USDB_TX_IDLE);
    status_word[ST_DBG_SEND] = IS_CHANNEL0 & debug_chan_send_status;
    status_word[ST_DBG_RECV] = IS_CHANNEL0 & debug_chan_recv_status;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic [31:0] cmd;
  logic sel_tick;
  logic baud_tick;
  logic bit_tick;
  logic rx_tick;
  logic start_to;
  logic char_done;
  logic [CHAR_W-1:0] rx_data;
  logic line;

  always_comb begin
    s_nxt = s_r;
    wr_acc = psel & penable & pwrite;
    rd_acc = psel & penable & ~pwrite;
    setup = psel & ~penable;
    cmd = (wr_acc && paddr == OFF_COMMAND) ? pwdata : '0;
    start_to = cmd[CMD_START_TIMEOUT];
    char_done = 1'b0;
    rx_data = '0;
    line = s_r.rxd_s2;

    s_nxt.rxd_s1 = rxd;
    s_nxt.rxd_s2 = s_r.rxd_s1;
    s_nxt.sck_s1 = sck_in;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_prev = s_r.sck_s2;

    // Baud generator; the external clock is counted on its rising edge
    sel_tick = ext_m ? (s_r.sck_s2 & ~s_r.sck_prev) : 1'b1;
    baud_tick = 1'b0;
    if (sync_m && ext_m) begin
      baud_tick = sel_tick;
    end else if (s_r.baud_divisor_value != '0 && sel_tick) begin
      if (s_r.div_cnt >= s_r.baud_divisor_value - 16'h0001) begin
        s_nxt.div_cnt = '0;
        baud_tick = 1'b1;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
      end
    end
    // Sixteen ticks per bit asynchronous, one per bit synchronous
    bit_tick = baud_tick & (sync_m | (s_r.os_cnt == OS_LAST));
    if (baud_tick) begin
      s_nxt.os_cnt = s_r.os_cnt + 4'h1;
    end
    // Duty is only even for an even divisor
    s_nxt.sck_level = sync_m & ~ext_m
                    & (s_r.div_cnt >= (s_r.baud_divisor_value >> 1));

    // ----------------------------------------------------------------
    // Register writes and commands
    // ----------------------------------------------------------------
    if (wr_acc) begin
      if (paddr == OFF_MODE) begin
        s_nxt.mode = pwdata[MODE_W-1:0];
      end else if (paddr == OFF_BAUD_DIVISOR) begin
        s_nxt.baud_divisor_value = pwdata[CD_W-1:0];
      end else if (paddr == OFF_RECEIVE_IDLE_TIMEOUT) begin
        s_nxt.idle_limit_value = pwdata[TO_W-1:0];
        start_to = 1'b1;
      end
    end
    if (cmd[CMD_RESET_STATUS]) begin
      s_nxt.break_seen_flag = 1'b0;
      s_nxt.rx_overrun_flag = 1'b0;
      s_nxt.frame_flag = 1'b0;
      s_nxt.parity_fault_flag = 1'b0;
    end
    if (cmd[CMD_RX_ENABLE]) begin
      s_nxt.rx_en = 1'b1;
    end
    if (cmd[CMD_RX_DISABLE]) begin
      s_nxt.rx_en = 1'b0;
    end
    if (cmd[CMD_TX_ENABLE]) begin
      s_nxt.tx_en = 1'b1;
    end
    if (cmd[CMD_TX_DISABLE]) begin
      s_nxt.tx_en = 1'b0;
    end
    // Holding read clears before the receiver runs, so a landing character wins
    if (rd_acc && paddr == OFF_RECEIVE_HOLDING) begin
      s_nxt.rx_ready = 1'b0;
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    if (cmd[CMD_BREAK_START] && s_r.tx_en) begin
      s_nxt.brk_pend = 1'b1;
    end
    case (s_r.tx_st)
      USDB_TX_IDLE: begin
        if (bit_tick && s_r.tx_en) begin
          if (s_r.brk_pend) begin
            s_nxt.brk_pend = 1'b0;
            s_nxt.tx_low = 1'b1;
            s_nxt.tx_st = USDB_TX_BREAK;
          end else if (s_r.tx_full) begin
            s_nxt.tx_shift = s_r.tx_hold;
            s_nxt.tx_par = (pmode == PAR_MULTIDROP) ? 1'b0 : par_calc(s_r.tx_hold, s_r.mode);
            s_nxt.tx_full = 1'b0;
            s_nxt.tx_cnt = '0;
            s_nxt.tx_low = 1'b1;
            s_nxt.tx_st = USDB_TX_DATA;
          end
        end
      end
      USDB_TX_DATA: begin
        if (bit_tick) begin
          if (s_r.tx_cnt == nb) begin
            if (pmode == PAR_NONE) begin
              s_nxt.tx_low = 1'b0;
              s_nxt.tx_st = USDB_TX_STOP;
            end else begin
              s_nxt.tx_low = ~s_r.tx_par;
              s_nxt.tx_st = USDB_TX_PAR;
            end
          end else begin
            s_nxt.tx_low = ~s_r.tx_shift[0];
            s_nxt.tx_shift = s_r.tx_shift >> 1;
            s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
          end
        end
      end
      USDB_TX_PAR: begin
        if (bit_tick) begin
          s_nxt.tx_low = 1'b0;
          s_nxt.tx_st = USDB_TX_STOP;
        end
      end
      USDB_TX_STOP: begin
        if (bit_tick) begin
          s_nxt.tx_st = USDB_TX_IDLE;
        end
      end
      USDB_TX_BREAK: begin
        if (cmd[CMD_BREAK_STOP]) begin
          s_nxt.tx_low = 1'b0;
          s_nxt.tx_st = USDB_TX_STOP;
        end
      end
      default: begin
        s_nxt.tx_st = USDB_TX_IDLE;
      end
    endcase
    // Writes made while the holding register is full replace the waiting character
    if (wr_acc && paddr == OFF_TRANSMIT_HOLDING && s_r.tx_en) begin
      s_nxt.tx_hold = pwdata[CHAR_W-1:0];
      s_nxt.tx_full = 1'b1;
    end
    if (!s_nxt.tx_en) begin
      s_nxt.tx_st = USDB_TX_IDLE;
      s_nxt.tx_full = 1'b0;
      s_nxt.brk_pend = 1'b0;
      s_nxt.tx_low = 1'b0;
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    rx_tick = baud_tick & (sync_m | (s_r.rx_os == OS_LAST));
    if (baud_tick) begin
      s_nxt.rx_os = s_r.rx_os + 4'h1;
    end
    case (s_r.rx_st)
      USDB_RX_IDLE: begin
        if (baud_tick && !line) begin
          s_nxt.rx_os = sync_m ? OS_LAST : OS_HALF;
          s_nxt.rx_st = USDB_RX_START;
        end
      end
      USDB_RX_START: begin
        if (rx_tick) begin
          s_nxt.rx_st = line ? USDB_RX_IDLE : USDB_RX_DATA;
          s_nxt.rx_cnt = '0;
          s_nxt.rx_shift = '0;
        end
      end
      USDB_RX_DATA: begin
        if (rx_tick) begin
          s_nxt.rx_shift = {line, s_r.rx_shift[CHAR_W-1:1]};
          s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          if (s_r.rx_cnt + 4'h1 == nb) begin
            s_nxt.rx_st = (pmode == PAR_NONE) ? USDB_RX_STOP : USDB_RX_PAR;
          end
        end
      end
      USDB_RX_PAR: begin
        if (rx_tick) begin
          s_nxt.rx_pbit = line;
          s_nxt.rx_st = USDB_RX_STOP;
        end
      end
      USDB_RX_STOP: begin
        if (rx_tick) begin
          rx_data = s_r.rx_shift >> (NINE_BITS - nb);
          s_nxt.rx_st = USDB_RX_IDLE;
          if (!line && rx_data == '0 && (pmode == PAR_NONE || !s_r.rx_pbit)) begin
            s_nxt.break_seen_flag = 1'b1;
            s_nxt.rx_st = USDB_RX_BREAK;
          end else begin
            char_done = 1'b1;
            if (!line) begin
              s_nxt.frame_flag = 1'b1;
            end
            if ((pmode == PAR_MULTIDROP && s_r.rx_pbit) ||
                ((pmode == PAR_EVEN || pmode == PAR_ODD) &&
                 s_r.rx_pbit != par_calc(rx_data, s_r.mode))) begin
              s_nxt.parity_fault_flag = 1'b1;
            end
            if (s_r.rx_ready) begin
              s_nxt.rx_overrun_flag = 1'b1;
            end
            s_nxt.rx_hold = rx_data;
            s_nxt.rx_ready = 1'b1;
          end
        end
      end
      USDB_RX_BREAK: begin
        if (baud_tick && line) begin
          s_nxt.break_seen_flag = 1'b1;
          s_nxt.rx_st = USDB_RX_IDLE;
        end
      end
      default: begin
        s_nxt.rx_st = USDB_RX_IDLE;
      end
    endcase
    if (!s_nxt.rx_en) begin
      s_nxt.rx_st = USDB_RX_IDLE;
      s_nxt.rx_ready = 1'b0;
      char_done = 1'b0;
    end

    // ----------------------------------------------------------------
    // Receive time-out, counted in whole bit periods
    // ----------------------------------------------------------------
    if (s_r.to_run && bit_tick) begin
      if (s_r.to_cnt <= 10'h001) begin
        s_nxt.to_flag = 1'b1;
        s_nxt.to_run = 1'b0;
      end else begin
        s_nxt.to_cnt = s_r.to_cnt - 10'h001;
      end
    end
    if (char_done && s_nxt.idle_limit_value != '0) begin
      s_nxt.to_cnt = {s_nxt.idle_limit_value, TO_BITS_PER_UNIT};
      s_nxt.to_run = 1'b1;
    end
    // Start waits for the next character before counting
    if (start_to) begin
      s_nxt.to_flag = 1'b0;
      s_nxt.to_run = 1'b0;
      s_nxt.to_cnt = {s_nxt.idle_limit_value, TO_BITS_PER_UNIT};
    end

    // ----------------------------------------------------------------
    // APB read data captured in the setup cycle, returned in the access
    // ----------------------------------------------------------------
    if (setup) begin
      s_nxt.rdata = '0;
      s_nxt.rerr = 1'b0;
      if (paddr == OFF_COMMAND) begin
        s_nxt.rdata = '0;
      end else if (paddr == OFF_MODE) begin
        s_nxt.rdata[MODE_W-1:0] = s_r.mode;
      end else if (paddr == OFF_CHANNEL_STATUS) begin
        s_nxt.rdata = status_word;
      end else if (paddr == OFF_RECEIVE_HOLDING) begin
        s_nxt.rdata[CHAR_W-1:0] = s_r.rx_hold;
      end else if (paddr == OFF_TRANSMIT_HOLDING) begin
        s_nxt.rdata = '0;
      end else if (paddr == OFF_BAUD_DIVISOR) begin
        s_nxt.rdata[CD_W-1:0] = s_r.baud_divisor_value;
      end else if (paddr == OFF_RECEIVE_IDLE_TIMEOUT) begin
        s_nxt.rdata[TO_W-1:0] = s_r.idle_limit_value;
      end else begin
        s_nxt.rerr = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_r.rdata;
  assign pready = psel & penable;
  assign pslverr = psel & penable & s_r.rerr;
  assign txd = ~s_r.tx_low;
  assign sck_out = s_r.sck_level;
  assign sck_oe = sync_m & ~ext_m;
  assign rx_char_available = s_r.rx_ready;
  assign tx_holding_free = status_word[ST_TX_READY];

endmodule
